// *** src/pcsm_pkg.sv ***
// Package with constants and carrier types for the port clock source mux
package pcsm_pkg;

  // Line mode codes
  localparam logic [2:0] PCSM_LM_OFF       = 3'h0;
  localparam logic [2:0] PCSM_LM_LIU_MAX   = 3'h3;
  localparam int         PCSM_LM_HIGH_BIT  = 2;

  // Loopback codes
  localparam logic [2:0] PCSM_LB_NONE      = 3'h0;
  localparam logic [2:0] PCSM_LB_CODE_001  = 3'h1;
  localparam logic [2:0] PCSM_LB_LINE      = 3'h2;
  localparam logic [2:0] PCSM_LB_PAYLOAD   = 3'h3;
  localparam logic [2:0] PCSM_LB_LINE_DIAG = 3'h6;
  localparam int         PCSM_LB_DIAG_BIT  = 2;

  // Rate adapter clock select width
  localparam int         PCSM_RA_SEL_W     = 2;

  // Reset values of the per-port settings
  localparam logic [2:0] PCSM_RST_LM       = 3'h0;
  localparam logic [2:0] PCSM_RST_LB       = 3'h0;

  // Synchroniser depth for pin clocks
  localparam int         PCSM_SYNC_STAGES  = 2;

  // Clock source selection codes
  typedef enum logic [1:0]
  {
    PCSM_SRC_RA   = 2'b00,
    PCSM_SRC_TXIN = 2'b01,
    PCSM_SRC_RXIN = 2'b10,
    PCSM_SRC_REC  = 2'b11
  } pcsm_src_t;

  // Per-port configuration as written by software
  typedef struct packed
  {
    logic [2:0] line_mode;
    logic [2:0] loopback_select;
    logic       loop_timing;
    logic       tx_pin_clock_select;
    logic       tx_line_timing_select;
    logic       overhead_mode;
  } pcsm_cfg_t;

  // Selected sources for the three clock paths
  typedef struct packed
  {
    pcsm_src_t tx_line;
    pcsm_src_t tx_int;
    pcsm_src_t rx_int;
  } pcsm_sel_t;

endpackage : pcsm_pkg

// *** src/pcsm_glitchless_mux.sv ***
// Glitch-free four-input clock level selector with gated switchover
`timescale 1ns/1ps
`default_nettype none
module pcsm_glitchless_mux
  import pcsm_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       reset_in,
  // Sources and selection
  input  wire logic [3:0] src_level_in,
  input  wire pcsm_src_t  sel_in,
  // Output clock level
  output logic            clk_out
);
  import pcsm_pkg::*;

  pcsm_src_t  active;
  logic       cur_level;
  logic       prev_level;
  logic       swap_now;
  logic       hold_low;

  assign cur_level = src_level_in[active];
  assign swap_now  = (sel_in != active) && !cur_level && !prev_level;

  // Switch only once the running source has been low for two samples,
  // so its high phase is never cut short
  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
      active <= PCSM_SRC_RA;
    else if (swap_now)
      active <= sel_in;
  end

  // After a switch, stay low until the new source is low, so that the
  // first pulse passed on is a whole one
  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
      hold_low <= 1'b0;
    else if (swap_now)
      hold_low <= 1'b1;
    else if (!cur_level)
      hold_low <= 1'b0;
  end

  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
      prev_level <= 1'b0;
    else
      prev_level <= cur_level;
  end

  // Old source is followed until it is low, then the output waits for the new one
  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
      clk_out <= 1'b0;
    else if (hold_low)
      clk_out <= 1'b0;
    else
      clk_out <= cur_level;
  end

endmodule : pcsm_glitchless_mux
`default_nettype wire

// *** src/pcsm_port_clock_mux.sv ***
// Per-port clock source selection for receive, transmit and line clocks
`timescale 1ns/1ps
`default_nettype none
// Function
// - LINE_INTERFACE_UNIT off, no rate adapter, no loopback: rx from line pin, tx from tx pin.
// - LINE_INTERFACE_UNIT off, rate adapter on, no loopback: rx from line pin, tx adapter.
// - Default rx clock: line pin when LINE_INTERFACE_UNIT off, recovered clock when on.
// - Default tx clock comes from the rate adapter clocks.
// - LINE_INTERFACE_UNIT enable decoded from line mode: 001..011 enabled, else disabled.
// - Overhead mode forces LINE_INTERFACE_UNIT enable low.
// - Line mode, loopback, loop timing, pin select held as writable settings.
// - Loop timing: all three outputs from recovered or rx line clock.
// - Tx line clock: rx source for codes 010,110,011; else adapter or tx pin.
// - Tx clock: rx source for 011; else adapter or tx pin.
// - Rx clock without diag loopback: recovered if LINE_INTERFACE_UNIT on, else rx pin.
// - Rx clock with diag loopback or 001/LINE_INTERFACE_UNIT off/pin: adapter or tx pin.
// - Tx line timing select chooses input or output clock timing.
// - Timing select 0 uses output clock timing, 1 input clock timing.
// - Payload loopback ignores framer-side transmit inputs.
// - Diagnostic loopback ignores receive line inputs.
module pcsm_port_clock_mux
  import pcsm_pkg::*;
#(
  parameter int RA_CLOCKS = 4,
  parameter int DATA_W    = 2
)
(
  // Clock and reset
  input  wire logic                     sys_clk_in,
  input  wire logic                     reset_in,
  // Configuration write port
  input  wire logic                     cfg_write_in,
  input  wire pcsm_cfg_t                cfg_in,
  input  wire logic [PCSM_RA_SEL_W-1:0] ra_select_in,
  // Clock sources
  input  wire logic                     tx_clock_in,
  input  wire logic                     rx_line_clock_in,
  input  wire logic                     recovered_clock_in,
  input  wire logic [RA_CLOCKS-1:0]     rate_adapter_clocks_in,
  // Signal groups timed by the selected clocks
  input  wire logic [DATA_W-1:0]        framer_tx_data_in,
  input  wire logic [DATA_W-1:0]        rx_line_data_in,
  input  wire logic [DATA_W-1:0]        tx_line_data_in,
  // Clock outputs
  output logic                          tx_line_clock_out,
  output logic                          tx_clock_out,
  output logic                          rx_clock_out,
  // Status and gated data
  output logic                          line_unit_enable_out,
  output pcsm_sel_t                     sel_out,
  output logic                          tx_line_output_timing_out,
  output logic [DATA_W-1:0]             framer_tx_data_out,
  output logic [DATA_W-1:0]             rx_line_data_out,
  output logic [DATA_W-1:0]             tx_line_data_out
);
  import pcsm_pkg::*;

  // Refuse sizes that the selection logic cannot serve
  if (RA_CLOCKS < 1 || RA_CLOCKS > (1 << PCSM_RA_SEL_W))
  begin : g_bad_ra_clocks
    $error("RA_CLOCKS out of range");
  end
  if (DATA_W < 1)
  begin : g_bad_data_w
    $error("DATA_W must be positive");
  end

  pcsm_cfg_t                  cfg;
  logic [PCSM_RA_SEL_W-1:0]   ra_sel;
  logic [3:1]                 s1;
  logic [3:1]                 s2;
  logic [3:0]                 s3;
  logic [3:0]                 ra_pad;
  logic [3:0]                 ra_s1;
  logic [3:0]                 ra_s2;
  logic                       ra_level;
  logic [3:0]                 src_level;
  logic                       liu_en;
  logic                       lb_diag;
  logic                       lb_payload;
  logic                       lb_to_line;
  logic                       lb_code_001;
  logic                       tx_edge;
  logic                       rx_edge;
  logic                       txl_edge;
  pcsm_sel_t                  next_sel;
  logic [DATA_W-1:0]          fr_s1;
  logic [DATA_W-1:0]          fr_s2;
  logic [DATA_W-1:0]          rl_s1;
  logic [DATA_W-1:0]          rl_s2;
  logic [DATA_W-1:0]          tl_s1;
  logic [DATA_W-1:0]          tl_s2;
  logic [DATA_W-1:0]          tl_pin_q;

  // Software settings, held per port
  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      cfg    <= '{line_mode: PCSM_RST_LM, loopback_select: PCSM_RST_LB, default: 1'b0};
      ra_sel <= '0;
    end
    else if (cfg_write_in)
    begin
      cfg    <= cfg_in;
      ra_sel <= ra_select_in;
    end
  end

  // Missing rate adapter clocks read as a quiet low
  always_comb
  begin
    ra_pad                = 4'h0;
    ra_pad[RA_CLOCKS-1:0] = rate_adapter_clocks_in;
  end

  // Two-stage synchronisers for all four clock sources
  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      s1    <= 3'h0;
      s2    <= 3'h0;
      ra_s1 <= 4'h0;
      ra_s2 <= 4'h0;
    end
    else
    begin
      s1    <= {recovered_clock_in, rx_line_clock_in, tx_clock_in};
      s2    <= s1;
      ra_s1 <= ra_pad;
      ra_s2 <= ra_s1;
    end
  end

  // Third stage for edge detection
  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
      s3 <= 4'h0;
    else
      s3 <= src_level;
  end

  assign src_level = {s2, ra_level};

  // Line interface enable is decoded from the settings, then registered for output
  always_comb
  begin
    liu_en = (cfg.line_mode != PCSM_LM_OFF) && !cfg.line_mode[PCSM_LM_HIGH_BIT]
             && (cfg.line_mode <= PCSM_LM_LIU_MAX);
    if (cfg.overhead_mode)
      liu_en = 1'b0;
  end

  assign lb_diag     = cfg.loopback_select[PCSM_LB_DIAG_BIT];
  assign lb_payload  = (cfg.loopback_select == PCSM_LB_PAYLOAD);
  assign lb_code_001 = (cfg.loopback_select == PCSM_LB_CODE_001);
  assign lb_to_line  = (cfg.loopback_select == PCSM_LB_LINE) ||
                       (cfg.loopback_select == PCSM_LB_LINE_DIAG) || lb_payload;

  // Source selection for each clock path
  always_comb
  begin
    pcsm_src_t rx_src;
    pcsm_src_t tx_src;
    rx_src = liu_en ? PCSM_SRC_REC : PCSM_SRC_RXIN;
    tx_src = cfg.tx_pin_clock_select ? PCSM_SRC_TXIN : PCSM_SRC_RA;
    next_sel = '{tx_line: tx_src, tx_int: tx_src, rx_int: rx_src};
    if (cfg.loop_timing)
      next_sel = '{tx_line: rx_src, tx_int: rx_src, rx_int: rx_src};
    else
    begin
      if (lb_to_line)
        next_sel.tx_line = rx_src;
      if (lb_payload)
        next_sel.tx_int = rx_src;
      if (lb_diag)
        next_sel.rx_int = tx_src;
      else if (lb_code_001 && !liu_en && cfg.tx_pin_clock_select)
        next_sel.rx_int = PCSM_SRC_TXIN;
      else
        next_sel.rx_int = rx_src;
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
      sel_out <= '{tx_line: PCSM_SRC_RA, tx_int: PCSM_SRC_RA, rx_int: PCSM_SRC_RXIN};
    else
      sel_out <= next_sel;
  end

  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
      line_unit_enable_out <= 1'b0;
    else
      line_unit_enable_out <= liu_en;
  end

  // A new rate adapter choice also switches without cutting a pulse
  pcsm_glitchless_mux u_ra_pick
  (
    .sys_clk_in   (sys_clk_in),
    .reset_in     (reset_in),
    .src_level_in (ra_s2),
    .sel_in       (pcsm_src_t'(ra_sel)),
    .clk_out      (ra_level)
  );

  // Independent glitch-free muxes, one per clock path
  pcsm_glitchless_mux u_tx_line
  (
    .sys_clk_in   (sys_clk_in),
    .reset_in     (reset_in),
    .src_level_in (src_level),
    .sel_in       (sel_out.tx_line),
    .clk_out      (tx_line_clock_out)
  );

  pcsm_glitchless_mux u_tx_int
  (
    .sys_clk_in   (sys_clk_in),
    .reset_in     (reset_in),
    .src_level_in (src_level),
    .sel_in       (sel_out.tx_int),
    .clk_out      (tx_clock_out)
  );

  pcsm_glitchless_mux u_rx_int
  (
    .sys_clk_in   (sys_clk_in),
    .reset_in     (reset_in),
    .src_level_in (src_level),
    .sel_in       (sel_out.rx_int),
    .clk_out      (rx_clock_out)
  );

  // Edge of each selected source, used to sample the data groups
  assign tx_edge  = src_level[sel_out.tx_int] & ~s3[sel_out.tx_int];
  assign rx_edge  = src_level[sel_out.rx_int] & ~s3[sel_out.rx_int];
  assign txl_edge = src_level[sel_out.tx_line] & ~s3[sel_out.tx_line];

  // Data group synchronisers
  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      fr_s1 <= '0;
      fr_s2 <= '0;
      rl_s1 <= '0;
      rl_s2 <= '0;
      tl_s1 <= '0;
      tl_s2 <= '0;
    end
    else
    begin
      fr_s1 <= framer_tx_data_in;
      fr_s2 <= fr_s1;
      rl_s1 <= rx_line_data_in;
      rl_s2 <= rl_s1;
      tl_s1 <= tx_line_data_in;
      tl_s2 <= tl_s1;
    end
  end

  // Framer transmit inputs are dropped during payload loopback
  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
      framer_tx_data_out <= '0;
    else if (lb_payload)
      framer_tx_data_out <= '0;
    else if (tx_edge)
      framer_tx_data_out <= fr_s2;
  end

  // Receive line inputs are dropped during diagnostic loopback
  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
      rx_line_data_out <= '0;
    else if (lb_diag)
      rx_line_data_out <= '0;
    else if (rx_edge)
      rx_line_data_out <= rl_s2;
  end

  // Transmit line group: output timing launches on the tx line clock edge,
  // input timing captures on the tx pin clock edge
  assign tx_line_output_timing_out = !cfg.tx_line_timing_select;

  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
      tl_pin_q <= '0;
    else if (cfg.tx_line_timing_select ? (s2[PCSM_SRC_TXIN] & ~s3[PCSM_SRC_TXIN]) : txl_edge)
      tl_pin_q <= tl_s2;
  end

  assign tx_line_data_out = tl_pin_q;

endmodule : pcsm_port_clock_mux
`default_nettype wire

// *** tb/pcsm_monitor.sv ***
// Assertion checker for the port clock source mux
`timescale 1ns/1ps
`default_nettype none
module pcsm_monitor
  import pcsm_pkg::*;
#(
  parameter int DATA_W = 2
)
(
  // Clock and reset
  input  wire logic              sys_clk_in,
  input  wire logic              reset_in,
  // Configuration
  input  wire logic              cfg_write_in,
  input  wire pcsm_cfg_t         cfg_in,
  // Observed outputs
  input  wire logic              rx_clock_out,
  input  wire logic              line_unit_enable_out,
  input  wire pcsm_sel_t         sel_out,
  input  wire logic              tx_line_output_timing_out,
  input  wire logic [DATA_W-1:0] framer_tx_data_out,
  input  wire logic [DATA_W-1:0] rx_line_data_out
);
  pcsm_cfg_t cfg_q;
  pcsm_cfg_t cfg_d;
  pcsm_sel_t exp_sel;
  logic      exp_luen;
  logic      plb_on;
  logic      dlb_on;

  function automatic logic luen_f(pcsm_cfg_t c);
    return (c.line_mode inside {[3'h1:3'h3]}) && !c.overhead_mode;
  endfunction : luen_f

  function automatic pcsm_sel_t exp_f(pcsm_cfg_t c);
    pcsm_src_t rs;
    pcsm_src_t ps;
    pcsm_sel_t s;
    rs = luen_f(c) ? PCSM_SRC_REC : PCSM_SRC_RXIN;
    ps = c.tx_pin_clock_select ? PCSM_SRC_TXIN : PCSM_SRC_RA;
    s.tx_line = (c.loop_timing || c.loopback_select inside {3'h2, 3'h3, 3'h6}) ? rs : ps;
    s.tx_int = (c.loop_timing || c.loopback_select == 3'h3) ? rs : ps;
    s.rx_int = rs;
    if (!c.loop_timing && (c.loopback_select[2] ||
        (c.loopback_select == 3'h1 && !luen_f(c) && c.tx_pin_clock_select)))
      s.rx_int = ps;
    return s;
  endfunction : exp_f

  // Stored settings and the copy that the registered outputs reflect
  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      cfg_q <= '0;
      cfg_d <= '0;
    end
    else
    begin
      if (cfg_write_in)
        cfg_q <= cfg_in;
      cfg_d <= cfg_q;
    end
  end

  assign exp_sel = exp_f(cfg_d);
  assign exp_luen = luen_f(cfg_d);
  assign plb_on = cfg_q.loopback_select == PCSM_LB_PAYLOAD;
  assign dlb_on = cfg_q.loopback_select[PCSM_LB_DIAG_BIT];

  default clocking mon_cb @(posedge sys_clk_in);
  endclocking
  default disable iff (reset_in);

  sequence s_plb_held;
    plb_on [*8];
  endsequence
  sequence s_dlb_held;
    dlb_on [*8];
  endsequence

  AST_TXL: assert property (sel_out.tx_line == exp_sel.tx_line)
    else $error("tx line clock source wrong");
  AST_TXI: assert property (sel_out.tx_int == exp_sel.tx_int)
    else $error("tx clock source wrong");
  AST_RXI: assert property (sel_out.rx_int == exp_sel.rx_int)
    else $error("rx clock source wrong");
  AST_LT: assert property (cfg_d.loop_timing |-> sel_out.tx_line == sel_out.rx_int
    && sel_out.tx_int == sel_out.rx_int)
    else $error("loop timed sources differ");
  AST_LUEN: assert property (line_unit_enable_out == exp_luen)
    else $error("line unit enable wrong");
  AST_TX_LINE_TIMING_SELECT: assert property (tx_line_output_timing_out == !cfg_q.tx_line_timing_select)
    else $error("tx line timing wrong");
  AST_PLB: assert property (s_plb_held |-> framer_tx_data_out == '0)
    else $error("framer data not ignored");
  AST_DLB: assert property (s_dlb_held |-> rx_line_data_out == '0)
    else $error("rx line data not ignored");
  AST_GATE: assert property ($rose(rx_clock_out) |-> rx_clock_out [*3])
    else $error("rx clock pulse cut short");
endmodule : pcsm_monitor

bind pcsm_port_clock_mux pcsm_monitor #(.DATA_W(DATA_W)) u_mon
(
  .sys_clk_in(sys_clk_in), .reset_in(reset_in), .cfg_write_in(cfg_write_in),
  .cfg_in(cfg_in), .rx_clock_out(rx_clock_out), .line_unit_enable_out(line_unit_enable_out),
  .sel_out(sel_out), .tx_line_output_timing_out(tx_line_output_timing_out),
  .framer_tx_data_out(framer_tx_data_out), .rx_line_data_out(rx_line_data_out)
);
`default_nettype wire

// *** tb/pcsm_line_partner.sv ***
// Far side model: free running line and rate adapter clocks, line data
`timescale 1ns/1ps
`default_nettype none
module pcsm_line_partner
(
  // Clocks
  output logic       tx_clk_out,
  output logic       rx_clk_out,
  output logic       rec_clk_out,
  output logic [3:0] ra_clks_out,
  // Data, never all zero
  output logic [1:0] data_out
);
  initial
  begin
    tx_clk_out = 1'b0;
    rx_clk_out = 1'b0;
    rec_clk_out = 1'b0;
    ra_clks_out = 4'h0;
    data_out = 2'h1;
  end
  initial #7 forever #32 tx_clk_out = ~tx_clk_out;
  initial #19 forever #32 rx_clk_out = ~rx_clk_out;
  initial #3 forever #32 rec_clk_out = ~rec_clk_out;
  for (genvar k = 0; k < 4; k++)
  begin : g_ra
    initial forever #(20 + 4 * k) ra_clks_out[k] = ~ra_clks_out[k];
  end
  // Data moves away from the rising edge it is timed to
  always @(negedge rx_clk_out)
    data_out <= ~data_out;
endmodule : pcsm_line_partner
`default_nettype wire

// *** tb/pcsm_port_clock_mux_tb.sv ***
// Self-checking testbench for the port clock source mux
`timescale 1ns/1ps
`default_nettype none
module pcsm_port_clock_mux_tb;
  import pcsm_pkg::*;
  // Row nibbles: line mode, loopback, {lt,pin,tls,ohm}, tx line, tx, rx source, enable
  localparam logic [27:0] ROWS [16] = '{28'h0000020, 28'h0041120, 28'h1020031, 28'h3051120,
    28'h4000020, 28'h2243131, 28'h0602000, 28'h1343331, 28'h0441110, 28'h0141110,
    28'h0100020, 28'h1483331, 28'h03A2220, 28'h1500001, 28'h1761111, 28'h52C2220};
  logic        sys_clk_in;
  logic        reset_in;
  logic        cfg_write;
  pcsm_cfg_t   cfg;
  pcsm_cfg_t   c;
  logic [1:0]  ra_sel;
  logic        txc, rxc, recc, txl_clk, tx_clk, rx_clk, luen, timing;
  logic [3:0]  ra;
  logic [1:0]  dat, fdat, rdat, tdat;
  pcsm_sel_t   sel;
  logic [27:0] r;
  int          fail_count, checks, i, k, n, e, m, q;

  pcsm_line_partner u_far (.tx_clk_out(txc), .rx_clk_out(rxc), .rec_clk_out(recc),
    .ra_clks_out(ra), .data_out(dat));
  pcsm_port_clock_mux DUT (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
    .cfg_write_in(cfg_write), .cfg_in(cfg), .ra_select_in(ra_sel), .tx_clock_in(txc),
    .rx_line_clock_in(rxc), .recovered_clock_in(recc), .rate_adapter_clocks_in(ra),
    .framer_tx_data_in(dat), .rx_line_data_in(dat), .tx_line_data_in(dat),
    .tx_line_clock_out(txl_clk), .tx_clock_out(tx_clk), .rx_clock_out(rx_clk),
    .line_unit_enable_out(luen), .sel_out(sel), .tx_line_output_timing_out(timing),
    .framer_tx_data_out(fdat), .rx_line_data_out(rdat), .tx_line_data_out(tdat));

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  task automatic write_cfg(input pcsm_cfg_t v, input logic [1:0] s, input int wait_n);
    @(posedge sys_clk_in);
    cfg_write <= 1'b1;
    cfg <= v;
    ra_sel <= s;
    @(posedge sys_clk_in);
    cfg_write <= 1'b0;
    repeat (wait_n) @(posedge sys_clk_in);
    #1;
  endtask : write_cfg

  task wrap_up;
    $display("Checks %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up

  initial
  begin
    sys_clk_in = 1'b0;
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end

  initial
  begin
    #50000;
    fail_count++;
    wrap_up();
  end

  initial
  begin
    reset_in = 1'b1;
    cfg_write = 1'b0;
    cfg = '0;
    ra_sel = 2'h0;
    fail_count = 0;
    checks = 0;
    repeat (4) @(posedge sys_clk_in);
    #1;
    check("reset sel", sel, {PCSM_SRC_RA, PCSM_SRC_RA, PCSM_SRC_RXIN});
    check("reset enable", luen, 1'h0);
    @(posedge sys_clk_in);
    reset_in <= 1'b0;
    for (i = 0; i < 16; i++)
    begin
      r = ROWS[i];
      c = '{r[26:24], r[22:20], r[19], r[18], r[17], r[16]};
      write_cfg(c, i[1:0], 3);
      check("sel", sel, {r[13:12], r[9:8], r[5:4]});
      check("enable", luen, r[0]);
      check("timing", timing, !r[17]);
    end
    // Tx clock frequency follows the chosen adapter clock or the tx pin
    for (k = 0; k < 5; k++)
    begin
      c = '0;
      c.tx_pin_clock_select = (k == 4);
      write_cfg(c, k[1:0], 20);
      e = 2000 / ((k < 4) ? 40 + 8 * k : 64);
      n = 0;
      m = 0;
      q = 0;
      fork
        #2000;
        forever @(posedge tx_clk) n++;
        forever @(posedge txl_clk) m++;
        forever @(posedge rx_clk) q++;
      join_any
      disable fork;
      check("tx clock edges", n >= e - 2 && n <= e + 2, 1'h1);
      check("tx line clock edges", m >= e - 2 && m <= e + 2, 1'h1);
      check("rx clock edges", q >= 29 && q <= 33, 1'h1);
    end
    c = '0;
    c.loopback_select = PCSM_LB_PAYLOAD;
    write_cfg(c, 2'h0, 30);
    check("framer gated", fdat, 2'h0);
    check("rx live", rdat != 2'h0, 1'h1);
    check("tx line live", tdat != 2'h0, 1'h1);
    c.loopback_select = 3'h4;
    write_cfg(c, 2'h0, 30);
    check("rx gated", rdat, 2'h0);
    check("framer live", fdat != 2'h0, 1'h1);
    @(posedge sys_clk_in);
    reset_in <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    #1;
    check("settings cleared", sel, {PCSM_SRC_RA, PCSM_SRC_RA, PCSM_SRC_RXIN});
    wrap_up();
  end
endmodule : pcsm_port_clock_mux_tb
`default_nettype wire
